// >>> rtl/parallel_fifo_host_port.v
// Byte-wide parallel FIFO port between an external host and the device
`include "fifo_port_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module parallel_fifo_host_port #(
   parameter W       = `FP_DATA_W,
   parameter TX_AW   = 4,
   parameter RX_AW   = 4,
   parameter CLKDIV  = `FP_CLKDIV
) (
   input  wire         mclk,
   input  wire         rst,
   input  wire         sync_mode,
   input  wire [W-1:0] data_bus_bits_i,
   output reg  [W-1:0] data_bus_bits_o,
   output wire         data_bus_bits_oe,
   output wire         tx_full_n,
   output wire         rx_empty_n,
   input  wire         wr_n,
   input  wire         rd_n,
   input  wire         oe_n,
   output reg          fifo_clkout,
   output wire [W-1:0] tx_data,
   output wire         tx_valid,
   input  wire         tx_ready,
   input  wire [W-1:0] rx_data,
   input  wire         rx_valid,
   output wire         rx_ready
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Three stages; only stages two and three are compared
   reg [2:0] wr_s_q;
   reg [2:0] rd_s_q;
   reg [2:0] oe_s_q;
   reg       wr_lvl_q;
   reg       rd_lvl_q;
   reg       oe_lvl_q;
   reg [W-1:0] d_s1_q;
   reg [W-1:0] d_s2_q;
   always @(posedge mclk) begin
      if (rst) begin
         wr_s_q   <= 3'h7;
         rd_s_q   <= 3'h7;
         oe_s_q   <= 3'h7;
         wr_lvl_q <= 1'b1;
         rd_lvl_q <= 1'b1;
         oe_lvl_q <= 1'b1;
         d_s1_q   <= {W{1'b0}};
         d_s2_q   <= {W{1'b0}};
      end else begin
         wr_s_q <= {wr_s_q[1:0], wr_n};
         rd_s_q <= {rd_s_q[1:0], rd_n};
         oe_s_q <= {oe_s_q[1:0], oe_n};
         d_s1_q <= data_bus_bits_i;
         d_s2_q <= d_s1_q;
         if (wr_s_q[1] == wr_s_q[2]) begin
            wr_lvl_q <= wr_s_q[2];
         end
         if (rd_s_q[1] == rd_s_q[2]) begin
            rd_lvl_q <= rd_s_q[2];
         end
         if (oe_s_q[1] == oe_s_q[2]) begin
            oe_lvl_q <= oe_s_q[2];
         end
      end
   end
   // Strobes count as asserted at zero
   wire wr_fall = wr_lvl_q & ~wr_s_q[2] & (wr_s_q[1] == wr_s_q[2]);
   wire rd_fall = rd_lvl_q & ~rd_s_q[2] & (rd_s_q[1] == rd_s_q[2]);
   wire rd_rise = ~rd_lvl_q & rd_s_q[2] & (rd_s_q[1] == rd_s_q[2]);
   // ----------------------------------------------------------------
   // Transmit path: host to device
   // ----------------------------------------------------------------
   wire tx_full;
   wire tx_empty;
   // Host needs the data stable through the strobe edge; the bus copy
   // is two stages deep so it lines up with the agreed strobe level
   byte_fifo #(.W(W), .AW(TX_AW)) u_tx (
      .mclk    (mclk),
      .rst     (rst),
      .wr_en   (wr_fall),
      .wr_data (d_s2_q),
      .rd_en   (tx_ready),
      .rd_data (tx_data),
      .full    (tx_full),
      .empty   (tx_empty)
   );
   assign tx_valid = ~tx_empty;
   // Flag goes high the cycle after the filling write; a write seen
   // while full is dropped by the FIFO
   assign tx_full_n = tx_full;
   // ----------------------------------------------------------------
   // Receive path: device to host
   // ----------------------------------------------------------------
   wire [W-1:0] rx_head;
   wire         rx_full;
   wire         rx_empty;
   byte_fifo #(.W(W), .AW(RX_AW)) u_rx (
      .mclk    (mclk),
      .rst     (rst),
      .wr_en   (rx_valid),
      .wr_data (rx_data),
      .rd_en   (rd_rise),
      .rd_data (rx_head),
      .full    (rx_full),
      .empty   (rx_empty)
   );
   assign rx_ready = ~rx_full;
   // High when nothing waits; rises once the last byte is popped
   assign rx_empty_n = rx_empty;
   // ----------------------------------------------------------------
   // Data bus drive
   // ----------------------------------------------------------------
   // Byte is latched at the falling strobe so it holds steady even if
   // new receive data lands during the read; a strobe while empty
   // drives stale data, which the host must avoid
   reg drive_q;
   always @(posedge mclk) begin
      if (rst) begin
         data_bus_bits_o <= {W{1'b0}};
         drive_q         <= 1'b0;
      end else begin
         if (rd_fall) begin
            data_bus_bits_o <= rx_head;
         end
         drive_q <= ~rd_s_q[2] & ~rd_s_q[1];
      end
   end
   // Output enable gates the drive only in synchronous mode
   assign data_bus_bits_oe = drive_q & (~sync_mode | ~oe_lvl_q);
   // ----------------------------------------------------------------
   // Clock output
   // ----------------------------------------------------------------
   // Divided from mclk; held low in strobe mode
   reg [7:0] div_q;
   always @(posedge mclk) begin
      if (rst) begin
         div_q       <= 8'h00;
         fifo_clkout <= 1'b0;
      end else if (!sync_mode) begin
         div_q       <= 8'h00;
         fifo_clkout <= 1'b0;
      end else if (div_q == CLKDIV[7:0] - 8'h01) begin
         div_q       <= 8'h00;
         fifo_clkout <= ~fifo_clkout;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end
endmodule // parallel_fifo_host_port
`default_nettype wire

// >>> rtl/fifo_port_defs.vh
// Constants for the parallel FIFO host port
// Notes on behaviour
// - The transmit-full flag is high whenever the host must not write, and the host writes only while it is low; the testbench writes once while high.
// - The receive-empty flag is low only while at least one byte waits in the receive FIFO.
// - On the falling edge of the write strobe the byte on the data bus enters the transmit FIFO.
// - While the read strobe is low the current receive byte is driven onto the data bus, else the bus is released.
// - Each read strobe advances the receive FIFO to its next byte if one is stored.
// - The output enable acts only in synchronous FIFO mode and is ignored in strobe mode.
// - The clock output is used only in synchronous FIFO mode and stays idle in strobe mode.
// - The port signals with the low marker in their names are active at logic zero, except tx_full_n and rx_empty_n, which are high when full or empty.
`ifndef FIFO_PORT_DEFS_VH
`define FIFO_PORT_DEFS_VH
`define FP_DATA_W    8
`define FP_TX_DEPTH  16
`define FP_RX_DEPTH  16
`define FP_CLKDIV    4
`endif

// >>> rtl/byte_fifo.v
// Small synchronous byte FIFO with honest full and empty
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
   parameter W  = 8,
   parameter AW = 4
) (
   input  wire         mclk,
   input  wire         rst,
   input  wire         wr_en,
   input  wire [W-1:0] wr_data,
   input  wire         rd_en,
   output wire [W-1:0] rd_data,
   output wire         full,
   output wire         empty
);
   reg [W-1:0] mem [0:(1<<AW)-1];
   reg [AW:0]  wp_q;
   reg [AW:0]  rp_q;
   wire        do_wr = wr_en & ~full;
   wire        do_rd = rd_en & ~empty;
   assign empty   = (wp_q == rp_q);
   assign full    = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   assign rd_data = mem[rp_q[AW-1:0]];
   always @(posedge mclk) begin
      if (do_wr) begin
         mem[wp_q[AW-1:0]] <= wr_data;
      end
   end
   always @(posedge mclk) begin
      if (rst) begin
         wp_q <= {(AW+1){1'b0}};
         rp_q <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wp_q <= wp_q + 1'b1;
         end
         if (do_rd) begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end
endmodule // byte_fifo
`default_nettype wire

// >>> sim/port_checker_assertions.sv
// Checker for the parallel FIFO host port
`timescale 1ns/1ps
`default_nettype none
module port_checker (
   input wire mclk,
   input wire rst,
   input wire sync_mode,
   input wire wr_n,
   input wire rd_n,
   input wire data_bus_bits_oe,
   input wire tx_full_n,
   input wire rx_empty_n,
   input wire fifo_clkout,
   input wire tx_valid,
   input wire rx_ready,
   input wire rx_valid
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_reset_flags: assert property ($fell(rst) |-> rx_empty_n && !tx_valid)
      else $error("flags wrong after reset");
   a_full_has_data: assert property (tx_full_n |-> tx_valid)
      else $error("full without data");
   a_empty_has_room: assert property (rx_empty_n |-> rx_ready)
      else $error("empty but not ready");
   a_push_shows: assert property (rx_valid && rx_ready |-> ##[1:3] !rx_empty_n)
      else $error("pushed byte not flagged");
   a_write_taken: assert property ($fell(wr_n) && !tx_full_n |-> ##[2:6] tx_valid)
      else $error("write not captured");
   a_drive_on_read: assert property ($rose(data_bus_bits_oe) |-> !rd_n && !$past(rd_n, 2))
      else $error("bus driven without read");
   a_bus_release: assert property (rd_n [*5] |-> !data_bus_bits_oe)
      else $error("bus not released");
   a_clk_idle: assert property (!sync_mode [*2] |-> !fifo_clkout)
      else $error("clock out in strobe mode");
   c_read: cover property ($rose(data_bus_bits_oe));
   c_full: cover property ($rose(tx_full_n));
   c_sync_clk: cover property (sync_mode && fifo_clkout);
endmodule // port_checker
bind parallel_fifo_host_port port_checker chk (.*);
`default_nettype wire

// >>> sim/host_model.sv
// Host model: strobes and the shared data bus
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire       mclk,
   input  wire       oe,
   input  wire [7:0] dev_d,
   output wire [7:0] bus,
   output reg        wr_n,
   output reg        rd_n
);
   reg [7:0] hd;
   // Released bus shows the inverse of the last byte written, and 0 before the first write
   assign bus = oe ? dev_d : hd;
   initial begin
      wr_n = 1'b1;
      rd_n = 1'b1;
      hd = 8'h00;
   end
   task wr(input [7:0] b);
      begin
         @(posedge mclk);
         hd <= b;
         repeat (2) @(posedge mclk);
         wr_n <= 1'b0;
         repeat (4) @(posedge mclk);
         wr_n <= 1'b1;
         hd <= ~b;
         repeat (3) @(posedge mclk);
      end
   endtask
   task rd(output [7:0] b);
      begin
         @(posedge mclk);
         rd_n <= 1'b0;
         repeat (5) @(posedge mclk);
         b = bus;
         rd_n <= 1'b1;
         repeat (5) @(posedge mclk);
      end
   endtask
endmodule // host_model
`default_nettype wire

// >>> sim/parallel_fifo_host_port_tb.sv
// Testbench: host model and streams against queue models
`timescale 1ns/1ps
`default_nettype none
module parallel_fifo_host_port_tb;
   reg mclk = 0, rst = 1, sync_mode = 0, oe_n = 1, tx_ready = 0, rx_valid = 0;
   reg [7:0] rx_data = 8'h00, v;
   wire [7:0] bus, d_o, tx_data;
   wire oe, txf, rxe, wr_n, rd_n, tx_valid, rx_ready, clko;
   integer err_count = 0, check_count = 0, seed = 32'h67c4, i;
   integer oe_cnt = 0, clk_cnt = 0, mark = 0;
   reg clk_prev = 0;
   reg [7:0] txq[$], rxq[$];
   always #4 mclk = ~mclk;
   host_model host (.mclk(mclk), .oe(oe), .dev_d(d_o), .bus(bus), .wr_n(wr_n), .rd_n(rd_n));
   parallel_fifo_host_port uut (.mclk(mclk), .rst(rst), .sync_mode(sync_mode),
      .data_bus_bits_i(bus), .data_bus_bits_o(d_o), .data_bus_bits_oe(oe), .tx_full_n(txf),
      .rx_empty_n(rxe), .wr_n(wr_n), .rd_n(rd_n), .oe_n(oe_n), .fifo_clkout(clko),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready));
   task cmp(input string n, input logic [7:0] e, input logic [7:0] s);
      begin
         check_count = check_count + 1;
         if (s !== e) begin
            err_count = err_count + 1;
            $display("mismatch %s exp %h got %h", n, e, s);
         end
      end
   endtask
   task close_out;
      begin
         $display("checks %0d errors %0d", check_count, err_count);
         if (err_count == 0 && check_count > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   // Counts cycles of bus drive and rising edges of the clock output
   always @(posedge mclk) begin
      clk_prev <= clko;
      if (oe === 1'b1) oe_cnt <= oe_cnt + 1;
      if (clko === 1'b1 && clk_prev === 1'b0) clk_cnt <= clk_cnt + 1;
   end
   always @(posedge mclk)
      if (tx_valid === 1'b1 && tx_ready)
         cmp("tx_data", txq.size() ? txq.pop_front() : ~tx_data, tx_data);
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      // Seventeenth write lands on a full FIFO and must vanish
      for (i = 0; i < 17; i = i + 1) begin
         v = $random(seed);
         if (i < 16) txq.push_back(v);
         host.wr(v);
         if (i == 15) cmp("tx_full_n", 8'h01, {7'h00, txf});
      end
      tx_ready <= 1'b1;
      repeat (24) @(posedge mclk);
      cmp("tx_left", 8'h00, 8'(txq.size()));
      cmp("tx_full_n", 8'h00, {7'h00, txf});
      repeat (3) begin
         @(posedge mclk);
         v = $random(seed);
         rx_valid <= 1'b1;
         rx_data <= v;
         rxq.push_back(v);
      end
      @(posedge mclk);
      rx_valid <= 1'b0;
      repeat (3) @(posedge mclk);
      cmp("rx_empty_n", 8'h00, {7'h00, rxe});
      repeat (3) begin
         host.rd(v);
         cmp("rd_byte", rxq.pop_front(), v);
      end
      cmp("rx_empty_n", 8'h01, {7'h00, rxe});
      cmp("clkout_idle", 8'h00, 8'(clk_cnt));
      sync_mode <= 1'b1;
      // Sync mode: first read with the enable off, second with it on
      for (i = 0; i < 2; i = i + 1) begin
         @(posedge mclk);
         v = $random(seed);
         rx_valid <= 1'b1;
         rx_data <= v;
         rxq.push_back(v);
         @(posedge mclk);
         rx_valid <= 1'b0;
         oe_n <= (i == 0);
         repeat (4) @(posedge mclk);
         mark = oe_cnt;
         host.rd(v);
         if (i == 0) cmp("oe_held_off", 8'h00, 8'(oe_cnt - mark));
         else cmp("rd_sync", rxq[0], v);
         rxq.delete(0);
      end
      // Clock out runs at mclk/8: five rising edges in forty cycles
      mark = clk_cnt;
      repeat (40) @(posedge mclk);
      cmp("clkout_rises", 8'h05, 8'(clk_cnt - mark));
      close_out;
   end
   initial begin
      repeat (3000) @(posedge mclk);
      err_count = err_count + 1;
      close_out;
   end
endmodule // parallel_fifo_host_port_tb
`default_nettype wire
